// [common/bsdp_pkg.sv]
// Constants shared by the burst SRAM double-data-rate port and its storage array.
// Assumes one 100 MHz clock and byte addresses on the register bus.
package bsdp_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] BSDP_OFF_CTRL   = 8'h00;
  localparam logic [7:0] BSDP_OFF_STATUS = 8'h04;
  localparam logic [7:0] BSDP_OFF_RDCNT  = 8'h08;
  localparam logic [7:0] BSDP_OFF_WRCNT  = 8'h0C;
  localparam logic [7:0] BSDP_OFF_IGNCNT = 8'h10;

  // Control register fields and reset value.
  localparam int         BSDP_CTRL_BYPASS_N_BIT = 0;
  localparam int         BSDP_CTRL_RUN_BIT      = 1;
  localparam logic [1:0] BSDP_CTRL_RESET        = 2'h3;

  // Status register fields.
  localparam int BSDP_ST_RD_BUSY_BIT = 0;
  localparam int BSDP_ST_WR_BUSY_BIT = 1;
  localparam int BSDP_ST_OE_BIT      = 2;
  localparam int BSDP_ST_LAST_WR_BIT = 3;

  // Bus responses.
  localparam logic [1:0] BSDP_RESP_OKAY   = 2'h0;
  localparam logic [1:0] BSDP_RESP_SLVERR = 2'h2;

  // Burst timing in beats (one beat per clock edge, two beats per port cycle), and the lane width in bits.
  localparam int BSDP_BURST_LEN    = 4;
  localparam int BSDP_RD_SR_LEN    = 7;
  localparam int BSDP_WR_SR_LEN    = 5;
  localparam int BSDP_LAT2_TAP     = 3;
  localparam int BSDP_LAT1_TAP     = 1;
  localparam int BSDP_LANE_BITS    = 9;

  // Previous port cycle, used for arbitration of the shared address bus.
  typedef enum logic [2:0] {
    BSDP_OP_IDLE = 3'b001,
    BSDP_OP_RD   = 3'b010,
    BSDP_OP_WR   = 3'b100
  } bsdp_op_e;

endpackage

// [logic/bsdp_array.sv]
// Flip-flop storage for the burst SRAM port, four words per burst address.
// Assumes commit is a one-cycle pulse carrying a complete, masked four-beat burst.
`timescale 1ns/1ns
module bsdp_array
  import bsdp_pkg::*;
#(
  parameter int ADDR_W = 4,
  parameter int WIDTH  = 18,
  parameter int LANES  = 2
) (
  input  wire logic                           aclk,
  input  wire logic                           commit,
  input  wire logic [ADDR_W-1:0]              waddr,
  input  wire logic [BSDP_BURST_LEN*WIDTH-1:0] wbeats,
  input  wire logic [BSDP_BURST_LEN*LANES-1:0] wmask_n,
  input  wire logic [ADDR_W+1:0]              rindex,
  output logic      [WIDTH-1:0]               rword
);

  localparam int WORDS = BSDP_BURST_LEN * (1 << ADDR_W);

  logic [WIDTH-1:0] mem [WORDS];

  // Merges one beat into the stored word, lane by lane; a high mask keeps the old lane.
  function automatic logic [WIDTH-1:0] merge(input logic [WIDTH-1:0] old_w,
                                             input logic [WIDTH-1:0] new_w,
                                             input logic [LANES-1:0] mask_n);
    logic [WIDTH-1:0] res;
    res = old_w;
    for (int l = 0; l < LANES; l++) begin
      if (!mask_n[l]) begin
        res[l*BSDP_LANE_BITS +: BSDP_LANE_BITS] = new_w[l*BSDP_LANE_BITS +: BSDP_LANE_BITS];
      end
    end
    return res;
  endfunction

  // Asynchronous read of the addressed word.
  assign rword = mem[rindex];

  // Commits all four beats at once, each with its own lane masks. [R20] [R9] [R10] [R11] [R12] [R13] [R14]
  always_ff @(posedge aclk) begin
    if (commit) begin
      for (int b = 0; b < BSDP_BURST_LEN; b++) begin
        mem[{waddr, 2'(b)}] <= merge(mem[{waddr, 2'(b)}], wbeats[b*WIDTH +: WIDTH],
                                     wmask_n[b*LANES +: LANES]);
      end
    end
  end

  a_mask_none_keeps : assert property (@(posedge aclk) // [R11] [R14]
    commit && (&wmask_n[LANES-1:0]) |=> mem[{$past(waddr), 2'h0}] == $past(mem[{waddr, 2'h0}]))
    else $error("Fully masked beat altered the stored word.");

  a_mask_full_write : assert property (@(posedge aclk) // [R10] [R13]
    commit && !(|wmask_n[LANES-1:0]) |=> mem[{$past(waddr), 2'h0}] == $past(wbeats[WIDTH-1:0]))
    else $error("Unmasked beat was not written in full.");

endmodule

// [logic/bsdp_port.sv]
// Burst SRAM port with separate read and write data paths sharing one address bus.
// Assumes the controller is logic on aclk; each aclk edge is one data beat, k_rise_phase marks
// the positive-clock rises. Registers are reached over AXI4-Lite.
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ns
// Function
// R1 - Write address at K rise t; beats captured on both rises of t+1 and t+2.
// R2 - Read address at t; data beats driven on both rises of t+2 and t+3.
// R3 - Both selects high: no operation, write data ignored, read outputs tri-stated.
// R4 - With clocks stopped every data pin and internal state holds its previous value.
// R5 - After reset the device is deselected with read outputs tri-stated.
// R6 - Burst addresses run A, A+1, A+2, A+3 from the latched address.
// R7 - A second read or write on consecutive K rises is ignored.
// R8 - Read select is don't-care for a write when a read started last cycle.
// R9 - x18: mask 0 covers bits 8:0, mask 1 bits 17:9; masked lanes kept.
// R10 - x18: both masks low writes the full word.
// R11 - x18: both masks high writes nothing for that beat.
// R12 - x36: four masks cover four nine-bit lanes; masked lanes kept.
// R13 - x36: all masks low writes all four lanes.
// R14 - x36: all masks high writes nothing for that beat.
// R15 - Masks are sampled separately on every beat of the data portion.
// R16 - PLL bypass low selects one-cycle read latency.
// R17 - Both selected from idle: read first, then ports alternate.
// R18 - Output valid flag rises half a cycle before read data appears.
// R19 - On deselect, pending reads finish, then outputs tri-state after next K rise.
// R20 - A write burst is committed only after all four beats are captured.
module bsdp_port
  import bsdp_pkg::*;
#(
  parameter int ADDR_W = 4,
  parameter int WIDTH  = 18,
  parameter int LANES  = WIDTH / BSDP_LANE_BITS
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              read_port_select_n,
  input  wire logic              write_port_select_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [WIDTH-1:0]  wr_data,
  input  wire logic [LANES-1:0]  byte_lane_mask_n,
  output logic      [WIDTH-1:0]  rd_data,
  output logic                   rd_data_oe,
  output logic                   out_valid_flag,
  output logic                   k_rise_phase,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic      [1:0]        s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic      [31:0]       s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // Port state.
  logic                      kpos_reg;
  bsdp_op_e                  op_reg,       op_next;
  logic [BSDP_RD_SR_LEN-1:0] rd_sr_reg;
  logic [BSDP_WR_SR_LEN-1:0] wr_sr_reg;
  logic [ADDR_W-1:0]         rd_addr_reg,  out_addr_reg;
  logic [ADDR_W-1:0]         wr_addr_reg,  wr_caddr_reg;
  logic [3*WIDTH-1:0]        wbuf_reg;
  logic [3*LANES-1:0]        wmask_reg;
  logic [WIDTH-1:0]          rd_data_reg;
  logic                      rd_oe_reg,    flag_reg;
  logic [31:0]               rdcnt_reg,    wrcnt_reg,   igncnt_reg;
  // Register bus state.
  logic [1:0]                ctrl_reg;
  logic                      awready_reg,  wready_reg,  bvalid_reg;
  logic                      arready_reg,  rvalid_reg;
  logic                      aw_got_reg,   w_got_reg;
  logic [7:0]                awaddr_reg;
  logic [31:0]               wdata_reg,    rdata_reg;
  logic [3:0]                wstrb_reg;
  logic [1:0]                bresp_reg,    rresp_reg;

  // Picks the beat number from a one-hot window of the read shift register.
  function automatic logic [1:0] beat_of(input logic [3:0] taps);
    return taps[0] ? 2'h0 : taps[1] ? 2'h1 : taps[2] ? 2'h2 : 2'h3;
  endfunction

  // Tells whether a byte address hits one register word.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  // Control decode; run low models stopped input clocks. [R4]
  wire run      = ctrl_reg[BSDP_CTRL_RUN_BIT];
  wire bypass_n = ctrl_reg[BSDP_CTRL_BYPASS_N_BIT];
  wire k_rise   = run && kpos_reg;

  // Arbitration on a K rise: refuse back-to-back starts, read wins from idle. [R7] [R8] [R17] [R3]
  wire rd_ok    = !read_port_select_n && (op_reg != BSDP_OP_RD);
  wire wr_ok    = !write_port_select_n && (op_reg != BSDP_OP_WR);
  wire start_rd = k_rise && rd_ok;
  wire start_wr = k_rise && wr_ok && !start_rd;
  wire ignored  = k_rise && ((!read_port_select_n && !start_rd) || (!write_port_select_n && !start_wr));

  // Read output window: tap 3 for latency 2.0, tap 1 for latency 1.0. [R2] [R16]
  wire [3:0] rd_taps  = bypass_n ? rd_sr_reg[BSDP_LAT2_TAP +: 4] : rd_sr_reg[BSDP_LAT1_TAP +: 4];
  wire [3:0] flg_taps = bypass_n ? rd_sr_reg[BSDP_LAT2_TAP-1 +: 4] : rd_sr_reg[BSDP_LAT1_TAP-1 +: 4];
  wire       rd_load  = run && (|rd_taps);
  // Burst order A, A+1, A+2, A+3 from the address latched at the start. [R6]
  wire [ADDR_W-1:0] rd_burst_addr = rd_taps[0] ? rd_addr_reg : out_addr_reg;
  wire [ADDR_W+1:0] rd_index      = {rd_burst_addr, beat_of(rd_taps)};
  wire [WIDTH-1:0]  rd_word;

  // Write capture: beat k arrives k+1 edges after the start edge's successor. [R1] [R15]
  wire commit = run && wr_sr_reg[BSDP_WR_SR_LEN-1];
  wire [BSDP_BURST_LEN*WIDTH-1:0] wbeats = {wr_data, wbuf_reg};
  wire [BSDP_BURST_LEN*LANES-1:0] wmasks = {byte_lane_mask_n, wmask_reg};

  // Previous-cycle record for arbitration, updated on every K rise.
  always_comb begin
    op_next = op_reg;
    if (k_rise) begin
      unique case (1'b1)
        start_rd: op_next = BSDP_OP_RD;
        start_wr: op_next = BSDP_OP_WR;
        default:  op_next = BSDP_OP_IDLE;
      endcase
    end
  end

  // Beat phase, arbitration record and burst progress; all hold while stopped. [R4] [R5]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      kpos_reg  <= 1'b1;
      op_reg    <= BSDP_OP_IDLE;
      rd_sr_reg <= '0;
      wr_sr_reg <= '0;
    end else if (run) begin
      kpos_reg  <= !kpos_reg;
      op_reg    <= op_next;
      rd_sr_reg <= {rd_sr_reg[BSDP_RD_SR_LEN-2:0], start_rd};
      wr_sr_reg <= {wr_sr_reg[BSDP_WR_SR_LEN-2:0], start_wr};
    end
  end

  // Address latches; the copies keep a burst's address while the next one starts. [R6]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_addr_reg  <= '0;
      out_addr_reg <= '0;
      wr_addr_reg  <= '0;
      wr_caddr_reg <= '0;
    end else begin
      if (start_rd) rd_addr_reg <= addr;
      if (start_wr) wr_addr_reg <= addr;
      if (rd_load && rd_taps[0]) out_addr_reg <= rd_addr_reg;
      if (run && wr_sr_reg[0]) wr_caddr_reg <= wr_addr_reg;
    end
  end

  // Beats 0 to 2 and their masks are held; beat 3 goes to the array directly. [R1] [R15] [R20]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wbuf_reg  <= '0;
      wmask_reg <= '1;
    end else begin
      for (int b = 0; b < 3; b++) begin
        if (run && wr_sr_reg[b+1]) begin
          wbuf_reg[b*WIDTH +: WIDTH]  <= wr_data;
          wmask_reg[b*LANES +: LANES] <= byte_lane_mask_n;
        end
      end
    end
  end

  // Read outputs: load a beat, or tri-state at a K rise once the burst is done. [R3] [R5] [R18] [R19]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_data_reg <= '0;
      rd_oe_reg   <= 1'b0;
      flag_reg    <= 1'b0;
    end else if (run) begin
      if (rd_load) rd_data_reg <= rd_word;
      rd_oe_reg <= rd_load ? 1'b1 : (kpos_reg ? 1'b0 : rd_oe_reg);
      flag_reg  <= |flg_taps;
    end
  end

  // Burst counters seen by software.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdcnt_reg  <= '0;
      wrcnt_reg  <= '0;
      igncnt_reg <= '0;
    end else begin
      if (start_rd) rdcnt_reg <= rdcnt_reg + 32'h1;
      if (start_wr) wrcnt_reg <= wrcnt_reg + 32'h1;
      if (ignored) igncnt_reg <= igncnt_reg + 32'h1;
    end
  end

  bsdp_array #(
    .ADDR_W (ADDR_W),
    .WIDTH  (WIDTH),
    .LANES  (LANES)
  ) u_array (
    .aclk    (aclk),
    .commit  (commit),
    .waddr   (wr_caddr_reg),
    .wbeats  (wbeats),
    .wmask_n (wmasks),
    .rindex  (rd_index),
    .rword   (rd_word)
  );

  // Register bus decode.
  wire aw_hs    = s_axi_awvalid && awready_reg;
  wire w_hs     = s_axi_wvalid && wready_reg;
  wire do_write = aw_got_reg && w_got_reg && !bvalid_reg;
  wire ar_hs    = s_axi_arvalid && arready_reg;
  wire wr_ctrl  = hit(awaddr_reg, BSDP_OFF_CTRL);
  wire wr_known = wr_ctrl || hit(awaddr_reg, BSDP_OFF_STATUS) || hit(awaddr_reg, BSDP_OFF_RDCNT)
                  || hit(awaddr_reg, BSDP_OFF_WRCNT) || hit(awaddr_reg, BSDP_OFF_IGNCNT);
  wire [31:0] status_word = {28'h0, op_reg == BSDP_OP_WR, rd_oe_reg, |wr_sr_reg, |rd_sr_reg};
  wire        rd_known    = hit(s_axi_araddr, BSDP_OFF_CTRL) || hit(s_axi_araddr, BSDP_OFF_STATUS)
                            || hit(s_axi_araddr, BSDP_OFF_RDCNT) || hit(s_axi_araddr, BSDP_OFF_WRCNT)
                            || hit(s_axi_araddr, BSDP_OFF_IGNCNT);
  wire [31:0] rd_mux =
      hit(s_axi_araddr, BSDP_OFF_CTRL)   ? {30'h0, ctrl_reg} :
      hit(s_axi_araddr, BSDP_OFF_STATUS) ? status_word :
      hit(s_axi_araddr, BSDP_OFF_RDCNT)  ? rdcnt_reg :
      hit(s_axi_araddr, BSDP_OFF_WRCNT)  ? wrcnt_reg :
      hit(s_axi_araddr, BSDP_OFF_IGNCNT) ? igncnt_reg : 32'h0;

  // Write channel: address and data taken in either order, response after both.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= BSDP_RESP_OKAY;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
    end else begin
      if (aw_hs) begin
        awaddr_reg  <= s_axi_awaddr;
        aw_got_reg  <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (w_hs) begin
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
        w_got_reg  <= 1'b1;
        wready_reg <= 1'b0;
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_known ? BSDP_RESP_OKAY : BSDP_RESP_SLVERR;
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // Control register: only byte lane 0 carries bits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= BSDP_CTRL_RESET;
    end else if (do_write && wr_ctrl && wstrb_reg[0]) begin
      ctrl_reg <= wdata_reg[1:0];
    end
  end

  // Read channel: one cycle from address to data, held until taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= BSDP_RESP_OKAY;
    end else if (ar_hs) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_mux;
      rresp_reg   <= rd_known ? BSDP_RESP_OKAY : BSDP_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // Outputs straight from flip-flops.
  assign rd_data        = rd_data_reg;
  assign rd_data_oe     = rd_oe_reg;
  assign out_valid_flag = flag_reg;
  assign k_rise_phase   = kpos_reg;
  assign s_axi_awready  = awready_reg;
  assign s_axi_wready   = wready_reg;
  assign s_axi_bvalid   = bvalid_reg;
  assign s_axi_bresp    = bresp_reg;
  assign s_axi_arready  = arready_reg;
  assign s_axi_rvalid   = rvalid_reg;
  assign s_axi_rdata    = rdata_reg;
  assign s_axi_rresp    = rresp_reg;

  // Checks, valid while the control word is not changed and the clocks run.
  a_rd_lat_two : assert property (@(posedge aclk) disable iff (!aresetn || !run) // [R2]
    start_rd && bypass_n |-> ##5 (rd_oe_reg && $past(rd_taps[0])))
    else $error("Read data not driven two cycles after the read start.");

  a_rd_lat_one : assert property (@(posedge aclk) disable iff (!aresetn || !run) // [R16]
    start_rd && !bypass_n |-> ##3 (rd_oe_reg && $past(rd_taps[0])))
    else $error("Read data not driven one cycle after the read start.");

  a_flag_leads_data : assert property (@(posedge aclk) disable iff (!aresetn || !run) // [R18]
    $rose(rd_oe_reg) |-> $past(flag_reg))
    else $error("Valid flag did not lead read data by one beat.");

  a_no_back_read : assert property (@(posedge aclk) disable iff (!aresetn || !run) // [R7]
    start_rd |-> ##2 !start_rd)
    else $error("Read accepted on consecutive positive rises.");

  a_wr_commit_time : assert property (@(posedge aclk) disable iff (!aresetn || !run) // [R1] [R20]
    start_wr |-> ##4 !commit ##1 commit)
    else $error("Write burst not committed after its fourth beat.");

  a_read_priority : assert property (@(posedge aclk) disable iff (!aresetn) // [R17]
    k_rise && !read_port_select_n && !write_port_select_n && op_reg == BSDP_OP_IDLE
    |-> start_rd && !start_wr)
    else $error("Read did not win from the deselected state.");

  a_alternate_ports : assert property (@(posedge aclk) disable iff (!aresetn || !run) // [R17] [R8]
    start_rd && !write_port_select_n ##2 !write_port_select_n |-> start_wr)
    else $error("Write not served after a read with both ports selected.");

  a_oe_release : assert property (@(posedge aclk) disable iff (!aresetn) // [R19] [R3]
    rd_oe_reg && k_rise && !rd_load |=> !rd_oe_reg)
    else $error("Read outputs not tri-stated after the positive rise.");

  a_reset_tristate : assert property (@(posedge aclk) // [R5]
    !aresetn |=> !rd_oe_reg && !flag_reg)
    else $error("Read outputs driven after reset.");

  a_standby_hold : assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
    !run |=> $stable(rd_data_reg) && $stable(rd_oe_reg) && $stable(rd_sr_reg))
    else $error("Port state changed while the clocks were stopped.");

  c_read_burst   : cover property (@(posedge aclk) disable iff (!aresetn) start_rd ##5 rd_oe_reg);
  c_write_burst  : cover property (@(posedge aclk) disable iff (!aresetn) start_wr ##5 commit);
  c_alternating  : cover property (@(posedge aclk) disable iff (!aresetn) start_rd ##2 start_wr);
  c_ignored_req  : cover property (@(posedge aclk) disable iff (!aresetn) ignored);

endmodule

// [sim/bsdp_ctl_model.sv]
// Memory controller model that issues four-beat bursts on the port pins of the burst SRAM port.
// Assumes it shares aclk with the port and that k_rise_phase marks the coming K rise.
`timescale 1ns/1ns
module bsdp_ctl_model (
  input  wire logic        aclk,
  input  wire logic        k_rise_phase,
  input  wire logic [17:0] rd_data,
  input  wire logic        rd_data_oe,
  input  wire logic        out_valid_flag,
  output logic             read_port_select_n,
  output logic             write_port_select_n,
  output logic      [3:0]  addr,
  output logic      [17:0] wr_data,
  output logic      [1:0]  byte_lane_mask_n
);
  // Both ports start deselected.
  initial begin
    read_port_select_n  = 1'b1;
    write_port_select_n = 1'b1;
    addr                = 4'h0;
    wr_data             = 18'h0;
    byte_lane_mask_n    = 2'h3;
  end

  // Stops at the edge after which the next edge is a K rise.
  task automatic to_k();
    @(posedge aclk);
    for (int i = 0; i < 4 && k_rise_phase; i++) @(posedge aclk);
  endtask

  // Write burst to a; with dup a second start to b follows on the next K rise.
  task automatic wr(input logic [3:0] a, b, input logic [71:0] d, input logic [7:0] m, input bit dup);
    to_k();
    write_port_select_n <= 1'b0;
    addr                <= a;
    @(posedge aclk);
    write_port_select_n <= !dup;
    addr                <= b;
    @(posedge aclk);
    for (int k = 0; k < 4; k++) begin
      wr_data          <= d[18*k +: 18];
      byte_lane_mask_n <= m[2*k +: 2];
      if (k == 1) write_port_select_n <= 1'b1;
      @(posedge aclk);
    end
    // Released lines show the inverse so stale data is never mistaken for a beat.
    wr_data <= ~d[71:54];
    addr    <= ~b;
  endtask

  // Read burst; first is the edge of the first data beat.
  // With both, the write port stays selected over two K rises so a fully masked write alternates in.
  task automatic rd(input logic [3:0] a, input int first, input bit dup, both,
                    output logic [71:0] q, output logic vld, output logic [3:0] oe, output logic oe_end);
    to_k();
    read_port_select_n  <= 1'b0;
    write_port_select_n <= !both;
    addr                <= a;
    @(posedge aclk);
    read_port_select_n  <= !dup;
    byte_lane_mask_n    <= 2'h3;
    addr                <= ~a;
    repeat (2) @(posedge aclk);
    read_port_select_n  <= 1'b1;
    write_port_select_n <= 1'b1;
    repeat (first - 2) @(posedge aclk);
    vld = out_valid_flag;
    for (int k = 0; k < 4; k++) begin
      @(posedge aclk);
      q[18*k +: 18] = rd_data;
      oe[k]         = rd_data_oe;
    end
    @(posedge aclk);
    oe_end = rd_data_oe;
  endtask
endmodule

// [sim/tb.sv]
// Self-checking bench for the burst SRAM port: bursts through the controller model, registers over AXI4-Lite.
// Assumes the x18 width with sixteen burst addresses and a behavioural memory model kept here.
`timescale 1ns/1ns
module tb;
  import bsdp_pkg::*;
  logic        aclk, aresetn, read_port_select_n, write_port_select_n, rd_data_oe, out_valid_flag, k_rise_phase;
  logic [3:0]  addr;
  logic [17:0] wr_data, rd_data;
  logic [1:0]  byte_lane_mask_n, s_axi_bresp, s_axi_rresp, r;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, ign, wrc;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [17:0] mem_m [16][4];
  int          bad_count, check_count, seed;

  bsdp_port #(.ADDR_W(4), .WIDTH(18)) uut (.aclk, .aresetn, .read_port_select_n, .write_port_select_n, .addr,
    .wr_data, .byte_lane_mask_n, .rd_data, .rd_data_oe, .out_valid_flag, .k_rise_phase, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  bsdp_ctl_model ctl (.aclk, .k_rise_phase, .rd_data, .rd_data_oe, .out_valid_flag, .read_port_select_n,
    .write_port_select_n, .addr, .wr_data, .byte_lane_mask_n);

  // Free-running 100 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [71:0] e, g);
    check_count++;
    if (e !== g) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // AXI4-Lite write; address and data offered together, bready held until bvalid.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 50) chk("bus write timeout", 0, 1);
    if (n >= 50) final_report();
  endtask

  // AXI4-Lite read; rready held until rvalid.
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 50) chk("bus read timeout", 0, 1);
    if (n >= 50) final_report();
  endtask

  // Random write burst, mirrored into the model lane by lane where the mask is low.
  task automatic do_wr(input logic [3:0] a, input logic [7:0] m, input bit dup);
    logic [71:0] w;
    w = 72'({$urandom, $urandom, $urandom});
    ctl.wr(a, a + 4'h1, w, m, dup);
    for (int k = 0; k < 4; k++)
      for (int l = 0; l < 2; l++)
        if (!m[2*k+l]) mem_m[a][k][9*l +: 9] = w[18*k+9*l +: 9];
  endtask

  // Read burst compared with the model, with flag and output-enable timing.
  task automatic do_rd(input logic [3:0] a, input int first, input bit dup, both);
    logic [71:0] q;
    logic [3:0]  oe;
    logic        v, oe_end;
    ctl.rd(a, first, dup, both, q, v, oe, oe_end);
    chk("read burst", {mem_m[a][3], mem_m[a][2], mem_m[a][1], mem_m[a][0]}, q);
    chk("valid flag", 1, v);
    chk("oe beats", 4'hF, oe);
    chk("oe after burst", 0, oe_end);
  endtask

  // Main sequence.
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {8'h0, 8'h0, 32'h0, 4'hF};
    seed = $urandom(8781);
    repeat (16) @(posedge aclk);
    chk("oe in reset", 0, rd_data_oe);
    chk("flag in reset", 0, out_valid_flag);
    aresetn <= 1'b1;
    axi_rd(BSDP_OFF_CTRL, d, r);
    chk("ctrl reset", {30'h0, BSDP_CTRL_RESET}, d);
    axi_rd(8'h20, d, r);
    chk("unmapped read", {32'h0, BSDP_RESP_SLVERR}, {d, r});
    axi_wr(8'h24, 32'h1, r);
    chk("unmapped write", BSDP_RESP_SLVERR, r);
    axi_wr(BSDP_OFF_RDCNT, 32'h5, r);
    chk("read-only write", BSDP_RESP_OKAY, r);
    $display("test registers done");
    for (int a = 0; a < 16; a++) do_wr(4'(a), 8'h00, 0);
    for (int a = 0; a < 16; a++) do_rd(4'(a), 4, 0, 0);
    $display("test full writes done");
    do_wr(4'h3, 8'b11_00_10_01, 0);
    for (int a = 0; a < 16; a++) do_wr(4'(a), 8'($urandom), 0);
    for (int a = 0; a < 16; a++) do_rd(4'(a), 4, 0, 0);
    $display("test masked writes done");
    axi_rd(BSDP_OFF_IGNCNT, ign, r);
    axi_rd(BSDP_OFF_WRCNT, wrc, r);
    do_wr(4'h5, 8'h00, 1);
    do_rd(4'h6, 4, 0, 0);
    do_rd(4'h7, 4, 1, 0);
    do_rd(4'h8, 4, 0, 1);
    do_rd(4'h5, 4, 0, 0);
    axi_rd(BSDP_OFF_IGNCNT, d, r);
    chk("ignored count", ign + 32'h3, d);
    axi_rd(BSDP_OFF_WRCNT, d, r);
    chk("write count", wrc + 32'h2, d);
    $display("test refusals done");
    axi_wr(BSDP_OFF_CTRL, 32'h2, r);
    do_rd(4'h9, 2, 0, 0);
    axi_wr(BSDP_OFF_CTRL, 32'h1, r);
    {d[17:0], d[18], d[19]} = {rd_data, rd_data_oe, k_rise_phase};
    repeat (8) @(posedge aclk);
    chk("standby pins", {d[17:0], d[18], d[19]}, {rd_data, rd_data_oe, k_rise_phase});
    axi_wr(BSDP_OFF_CTRL, 32'h3, r);
    do_rd(4'hA, 4, 0, 0);
    axi_rd(BSDP_OFF_STATUS, d, r);
    chk("idle status", 32'h0, d);
    $display("test modes done");
    final_report();
  end
endmodule
